/* rtl/slr_pkg.sv */
// constants shared by the link lock recovery block
package slr_pkg;
	// ------------------------------------------------------------
	// framing
	// ------------------------------------------------------------
	localparam int          WORD_W           = 10;
	localparam int          FRAME_BITS       = WORD_W + 2;
	localparam logic [11:0] TRAINING_PATTERN = 12'hfc0;
	localparam int          START_BIT_POS    = FRAME_BITS - 1;
	localparam int          END_BIT_POS      = 0;

	// ------------------------------------------------------------
	// lock policy
	// ------------------------------------------------------------
	localparam int LOSS_FRAMES      = 4;
	localparam int RAND_LOCK_FRAMES = 8;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int LOCK_TIME_NS  = 2000;
	localparam int LOCK_TIME_CYC = LOCK_TIME_NS / CLK_PERIOD_NS;
	localparam int IDLE_TIME_NS  = 1600;
	localparam int IDLE_CYC      = (IDLE_TIME_NS / CLK_PERIOD_NS < 1) ? 1
	                               : IDLE_TIME_NS / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_HUNT   = 2'b00,
		ST_CHECK  = 2'b01,
		ST_LOCKED = 2'b10
	} slr_state_t;
endpackage

/* rtl/slr_word_if.sv */
// word stream between lock logic and output buffer
`timescale 1ns/1ps
`default_nettype none
interface slr_word_if #(parameter int WIDTH = 10);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* rtl/slr_word_buf.sv */
// small valid/ready buffer for recovered words
`timescale 1ns/1ps
`default_nettype none
module slr_word_buf #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst,
	// fill side
	slr_word_if.snk               fill,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
	logic [PW:0]      cnt_q, cnt_d;
	logic             push, pop;

	function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	assign fill.ready = (cnt_q != (PW+1)'(DEPTH));
	assign out_valid  = (cnt_q != '0);
	assign out_data   = mem_q[rd_q];
	assign push       = fill.valid && fill.ready;
	assign pop        = out_valid && out_ready;

	always_comb begin
		mem_d = mem_q;
		wr_d  = wr_q;
		rd_d  = rd_q;
		cnt_d = cnt_q;
		if (push) begin
			mem_d[wr_q] = fill.data;
			wr_d        = nxt(wr_q);
		end
		if (pop)
			rd_d = nxt(rd_q);
		if (push && !pop)
			cnt_d = cnt_q + (PW+1)'(1);
		else if (pop && !push)
			cnt_d = cnt_q - (PW+1)'(1);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
			for (int i = 0; i < DEPTH; i++)
				mem_q[i] <= '0;
		end else begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
			mem_q <= mem_d;
		end
	end
endmodule
`default_nettype wire

/* rtl/slr_lock_recovery.sv */
// receive-side framing, lock acquisition and loss-of-lock handling
`timescale 1ns/1ps
`default_nettype none
module slr_lock_recovery
	import slr_pkg::*;
#(
	parameter int BUF_DEPTH  = 2,
	parameter int LOSS_N     = LOSS_FRAMES,
	parameter int RAND_N     = RAND_LOCK_FRAMES,
	parameter int IDLE_N     = IDLE_CYC
) (
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst,
	// serial link pins
	input  wire logic              local_reference_clock,
	input  wire logic              link_data_in,
	input  wire logic              sleep_request_n,
	// lock status
	output logic                   lock_n,
	// recovered words
	output logic [WORD_W-1:0]      recovered_word_out,
	output logic                   recovered_word_oe,
	output logic                   word_valid,
	input  wire logic              word_ready,
	output logic                   word_overrun
);
	// ------------------------------------------------------------
	// pin synchronisers and bit strobe
	// ------------------------------------------------------------
	logic [1:0] clk_sync_q, dat_sync_q, slp_sync_q;
	logic       clk_prev_q;
	logic       bit_stb;
	logic       bit_val;
	logic       awake;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			clk_sync_q <= '0;
			dat_sync_q <= '0;
			slp_sync_q <= '0;
			clk_prev_q <= 1'b0;
		end else begin
			clk_sync_q <= {clk_sync_q[0], local_reference_clock};
			dat_sync_q <= {dat_sync_q[0], link_data_in};
			slp_sync_q <= {slp_sync_q[0], sleep_request_n};
			clk_prev_q <= clk_sync_q[1];
		end
	end

	assign bit_stb = clk_sync_q[1] && !clk_prev_q;
	assign bit_val = dat_sync_q[1];
	assign awake   = slp_sync_q[1];

	// ------------------------------------------------------------
	// framing and lock state
	// ------------------------------------------------------------
	localparam int CW = $clog2(FRAME_BITS);
	localparam int GW = $clog2(RAND_N + 1);
	localparam int LW = $clog2(LOSS_N + 1);
	localparam int IW = $clog2(IDLE_N + 1);

	slr_state_t            st_q, st_d;
	logic [FRAME_BITS-1:0] sr_q, sr_d;
	logic [CW-1:0]         bit_q, bit_d;
	logic [GW-1:0]         good_q, good_d;
	logic [LW-1:0]         bad_q, bad_d;
	logic [IW-1:0]         idle_q, idle_d;
	logic                  seen_q, seen_d;
	logic                  push;
	logic [WORD_W-1:0]     push_data;
	logic                  ovr_d, ovr_q;

	slr_word_if #(.WIDTH(WORD_W)) word_bus ();

	function automatic logic clk_bits_ok(input logic [FRAME_BITS-1:0] f);
		return f[START_BIT_POS] && !f[END_BIT_POS];
	endfunction

	always_comb begin
		st_d      = st_q;
		sr_d      = sr_q;
		bit_d     = bit_q;
		good_d    = good_q;
		bad_d     = bad_q;
		idle_d    = idle_q;
		seen_d    = seen_q;
		push      = 1'b0;
		push_data = sr_q[WORD_W:1];
		ovr_d     = 1'b0;
		if (bit_stb) begin
			sr_d   = {sr_q[FRAME_BITS-2:0], bit_val};
			idle_d = '0;
			seen_d = 1'b1;
			bit_d  = (bit_q == CW'(FRAME_BITS - 1)) ? '0 : bit_q + CW'(1);
			push_data = sr_d[WORD_W:1];
			case (st_q)
				ST_HUNT: begin
					// slide one bit at a time until framing is found
					if (sr_d == TRAINING_PATTERN) begin
						st_d  = ST_LOCKED;
						bit_d = '0;
						bad_d = '0;
					end else if (clk_bits_ok(sr_d)) begin
						st_d   = ST_CHECK;
						bit_d  = '0;
						good_d = GW'(1);
					end
				end
				ST_CHECK: begin
					// a training pattern wins over the frame under test
					if (sr_d == TRAINING_PATTERN) begin
						st_d  = ST_LOCKED;
						bit_d = '0;
						bad_d = '0;
					end else if (bit_q == CW'(FRAME_BITS - 1)) begin
						if (!clk_bits_ok(sr_d)) begin
							st_d = ST_HUNT;
						end else if (good_q == GW'(RAND_N - 1)) begin
							st_d  = ST_LOCKED;
							bad_d = '0;
						end else begin
							good_d = good_q + GW'(1);
						end
					end
				end
				ST_LOCKED: begin
					if (bit_q == CW'(FRAME_BITS - 1)) begin
						// words around a loss of lock still go out
						push = 1'b1;
						if (clk_bits_ok(sr_d)) begin
							bad_d = '0;
						end else if (bad_q == LW'(LOSS_N - 1)) begin
							st_d = ST_HUNT;
							bad_d = '0;
						end else begin
							bad_d = bad_q + LW'(1);
						end
					end
				end
				default: st_d = ST_HUNT;
			endcase
		end else if (idle_q != IW'(IDLE_N)) begin
			idle_d = idle_q + IW'(1);
		end else begin
			st_d   = ST_HUNT;
			seen_d = 1'b0;
		end
		if (!awake) begin
			st_d   = ST_HUNT;
			seen_d = 1'b0;
			push   = 1'b0;
		end
		if (push && !word_bus.ready)
			ovr_d = 1'b1;
	end

	assign word_bus.valid = push;
	assign word_bus.data  = push_data;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_q   <= ST_HUNT;
			sr_q   <= '0;
			bit_q  <= '0;
			good_q <= '0;
			bad_q  <= '0;
			idle_q <= '0;
			seen_q <= 1'b0;
			ovr_q  <= 1'b0;
		end else begin
			st_q   <= st_d;
			sr_q   <= sr_d;
			bit_q  <= bit_d;
			good_q <= good_d;
			bad_q  <= bad_d;
			idle_q <= idle_d;
			seen_q <= seen_d;
			ovr_q  <= ovr_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	logic locked;

	assign locked            = (st_q == ST_LOCKED) && seen_q;
	assign lock_n            = !locked;
	assign recovered_word_oe = locked;
	assign word_overrun      = ovr_q;

	slr_word_buf #(
		.WIDTH (WORD_W),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.fill      (word_bus.snk),
		.out_valid (word_valid),
		.out_ready (word_ready),
		.out_data  (recovered_word_out)
	);
endmodule
`default_nettype wire

/* testbench/slr_chk.sv */
// port assertions for the lock recovery block
`timescale 1ns/1ps
`default_nettype none
module slr_chk
	import slr_pkg::*;
#(parameter int IDLE_N = IDLE_CYC) (
	// clock and reset
	input wire logic              sys_clk,
	input wire logic              rst,
	// link and status
	input wire logic              local_reference_clock,
	input wire logic              sleep_request_n,
	input wire logic              lock_n,
	input wire logic              recovered_word_oe,
	// words
	input wire logic [WORD_W-1:0] recovered_word_out,
	input wire logic              word_valid,
	input wire logic              word_ready,
	input wire logic              word_overrun
);
	// cycles since the link clock last moved
	logic       ref_q;
	logic [7:0] idle_q;
	logic [7:0] idle_d;
	always_comb begin
		idle_d = idle_q + {7'h00, idle_q != 8'hff};
		if (local_reference_clock != ref_q)
			idle_d = 8'h00;
	end
	always_ff @(posedge sys_clk) begin
		ref_q <= local_reference_clock;
		idle_q <= rst ? 8'h00 : idle_d;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_oe; recovered_word_oe == !lock_n; endproperty
	a_oe: assert property (p_oe) else $error("oe differs from lock");
	property p_reset; $fell(rst) |-> lock_n && !recovered_word_oe && !word_valid; endproperty
	a_reset: assert property (p_reset) else $error("bad state after reset");
	property p_sleep; !sleep_request_n [*5] |-> lock_n; endproperty
	a_sleep: assert property (p_sleep) else $error("locked while asleep");
	property p_idle; idle_q > IDLE_N + 4 |-> lock_n; endproperty
	a_idle: assert property (p_idle) else $error("locked on a silent link");
	property p_hold; $fell(lock_n) |-> !lock_n [*8]; endproperty
	a_hold: assert property (p_hold) else $error("lock lost too soon");
	property p_push; $rose(word_valid) |-> !$past(lock_n); endproperty
	a_push: assert property (p_push) else $error("word pushed unlocked");
	property p_stall;
		word_valid && !word_ready && !lock_n |=>
			lock_n || (word_valid && $stable(recovered_word_out));
	endproperty
	a_stall: assert property (p_stall) else $error("head word lost in stall");
	property p_ovr; word_overrun |-> $past(word_valid) ##1 !word_overrun; endproperty
	a_ovr: assert property (p_ovr) else $error("bad overrun pulse");
endmodule
bind slr_lock_recovery slr_chk #(.IDLE_N(IDLE_N)) i_slr_chk (.sys_clk(sys_clk), .rst(rst),
	.local_reference_clock(local_reference_clock), .sleep_request_n(sleep_request_n),
	.lock_n(lock_n), .recovered_word_oe(recovered_word_oe),
	.recovered_word_out(recovered_word_out), .word_valid(word_valid),
	.word_ready(word_ready), .word_overrun(word_overrun));
`default_nettype wire

/* testbench/slr_ser_model.sv */
// serializer model: framed words with two clock bits, training patterns on request
`timescale 1ns/1ps
`default_nettype none
module slr_ser_model
	import slr_pkg::*;
(
	// control
	input  wire logic send_en,
	input  wire logic sync_request_a,
	input  wire logic sync_request_b,
	input  wire logic bad_clk,
	// link
	output var logic  link_clk,
	output var logic  link_data,
	output var int    frames_sent
);
	logic [FRAME_BITS-1:0] frame;
	initial begin
		link_clk = 1'b0;
		link_data = 1'b0;
		frames_sent = 0;
		forever begin
			if (send_en !== 1'b1) begin
				// released line: clock stands, data wanders
				#100 link_data = ~link_data;
			end else begin
				if (sync_request_a === 1'b1 || sync_request_b === 1'b1)
					frame = TRAINING_PATTERN;
				else
					frame = {~bad_clk, 10'(frames_sent), bad_clk};
				for (int i = FRAME_BITS - 1; i >= 0; i--) begin
					link_data = frame[i];
					#100 link_clk = 1'b1;
					#100 link_clk = 1'b0;
				end
				frames_sent++;
			end
		end
	end
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// self-checking bench for the lock recovery block
`timescale 1ns/1ps
`default_nettype none
module testbench
	import slr_pkg::*;
;
	logic              sys_clk = 1'b0, rst = 1'b1, sleep_request_n = 1'b1, word_ready = 1'b1;
	logic              send_en = 1'b0, bad_clk = 1'b0, sync_en = 1'b1, sync_b = 1'b0;
	logic              link_clk, link_data, lock_n, oe, word_valid, word_overrun;
	logic [WORD_W-1:0] word;
	logic [WORD_W-1:0] got[$];
	int                frames, failures = 0, samples_checked = 0, overruns = 0;
	always #12.5 sys_clk = ~sys_clk;
	slr_lock_recovery #(.IDLE_N(16)) i_slr_lock_recovery (.sys_clk(sys_clk), .rst(rst),
		.local_reference_clock(link_clk), .link_data_in(link_data),
		.sleep_request_n(sleep_request_n), .lock_n(lock_n), .recovered_word_out(word),
		.recovered_word_oe(oe), .word_valid(word_valid), .word_ready(word_ready),
		.word_overrun(word_overrun));
	slr_ser_model i_slr_ser_model (.send_en(send_en), .sync_request_a(lock_n & sync_en),
		.sync_request_b(sync_b), .bad_clk(bad_clk), .link_clk(link_clk),
		.link_data(link_data), .frames_sent(frames));
	always @(posedge sys_clk) begin
		if (word_valid === 1'b1 && word_ready === 1'b1) got.push_back(word);
		if (word_overrun === 1'b1) overruns++;
	end
	task automatic chk(string what, logic [31:0] exp, logic [31:0] act);
		samples_checked++;
		if (act !== exp) begin
			failures++;
			$display("wrong value %s expected %0h seen %0h", what, exp, act);
		end
	endtask
	task automatic frames_pass(int n);
		repeat (n) @(frames);
		repeat (2) @(posedge sys_clk);
	endtask
	task automatic lock_wait(int n);
		int f0;
		f0 = frames;
		while (lock_n !== 1'b0 && frames - f0 < n) @(posedge sys_clk);
		chk("lock_n", 0, 32'(lock_n));
	endtask
	task automatic t_sync_lock();
		repeat (200) @(posedge sys_clk);
		chk("lock_n", 1, 32'(lock_n));
		chk("oe", 0, 32'(oe));
		send_en <= 1'b1;
		lock_wait(3);
		chk("oe", 1, 32'(oe));
	endtask
	task automatic t_stream();
		got.delete();
		frames_pass(6);
		chk("count", 1, 32'(got.size() >= 5));
		for (int i = 1; i < got.size(); i++) chk("word", 32'(got[i-1]) + 1, 32'(got[i]));
	endtask
	task automatic t_stall();
		word_ready <= 1'b0;
		overruns = 0;
		frames_pass(4);
		chk("valid", 1, 32'(word_valid));
		chk("overruns", 2, 32'(overruns));
		got.delete();
		word_ready <= 1'b1;
		frames_pass(1);
		chk("kept", 32'(got[0]) + 1, 32'(got[1]));
		chk("after drop", 32'(got[1]) + 3, 32'(got[2]));
	endtask
	task automatic t_loss();
		bad_clk <= 1'b1;
		got.delete();
		frames_pass(4);
		chk("lock_n", 0, 32'(lock_n));
		frames_pass(1);
		chk("lock_n", 1, 32'(lock_n));
		chk("oe", 0, 32'(oe));
		chk("suspect words", 5, 32'(got.size()));
		chk("suspect data", 32'(got[0]) + 4, 32'(got[4]));
		bad_clk <= 1'b0;
		lock_wait(3);
	endtask
	task automatic t_random();
		sync_en <= 1'b0;
		// let the fresh lock stand before sleeping
		repeat (16) @(posedge sys_clk);
		sleep_request_n <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk("lock_n", 1, 32'(lock_n));
		sleep_request_n <= 1'b1;
		lock_wait(12);
	endtask
	task automatic t_idle();
		send_en <= 1'b0;
		frames_pass(1);
		repeat (30) @(posedge sys_clk);
		chk("lock_n", 1, 32'(lock_n));
		chk("oe", 0, 32'(oe));
		sync_b <= 1'b1;
		send_en <= 1'b1;
		lock_wait(3);
		sync_b <= 1'b0;
	endtask
	task automatic end_of_test();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#300_000;
		failures++;
		end_of_test();
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		t_sync_lock();
		t_stream();
		t_stall();
		t_loss();
		t_random();
		t_idle();
		end_of_test();
	end
endmodule
`default_nettype wire
